//--- common/rgr_defs.vh
// Purpose: constants for the reset generation and recording block
// Assumes: 100 MHz clock
// Notes:   output bit order {core_periph, always_on_periph, dap, cpu_core, power_on_domain}
`ifndef RGR_DEFS_VH
`define RGR_DEFS_VH

// reset output mask bit positions
`define RGR_OUT_POD        0
`define RGR_OUT_CPU        1
`define RGR_OUT_DAP        2
`define RGR_OUT_AON        3
`define RGR_OUT_CPER       4

// source-to-output masks
`define RGR_MAP_AON_POR    5'h1f
`define RGR_MAP_LV_WAKE    5'h17
`define RGR_MAP_LV_COLD    5'h1f
`define RGR_MAP_PIN        5'h1b
`define RGR_MAP_WDOG       5'h1a
`define RGR_MAP_SWREQ      5'h1a
`define RGR_MAP_OPTFAIL    5'h13
`define RGR_MAP_DSLEEP     5'h17
`define RGR_MAP_EMU_SLEEP  5'h12
`define RGR_MAP_DBG        5'h02

// reset cause codes
`define RGR_CAUSE_NONE     4'h0
`define RGR_CAUSE_AON_POR  4'h1
`define RGR_CAUSE_LV_POR   4'h2
`define RGR_CAUSE_PIN      4'h3
`define RGR_CAUSE_WDOG     4'h4
`define RGR_CAUSE_SWREQ    4'h5
`define RGR_CAUSE_WAKE     4'h6
`define RGR_CAUSE_OPTFAIL  4'h7
`define RGR_CAUSE_LOCKUP   4'h8

// clock source select
`define RGR_CLK_RC         1'b0
`define RGR_CLK_XTAL       1'b1

// crystal start-up times in microseconds, and clock rate
`define RGR_XTAL_MAXBIAS_US  1000
`define RGR_XTAL_OPTBIAS_US  2000
`define RGR_CLK_MHZ          100
`define RGR_XTAL_MAXBIAS_CYC (`RGR_XTAL_MAXBIAS_US * `RGR_CLK_MHZ)
`define RGR_XTAL_OPTBIAS_CYC (`RGR_XTAL_OPTBIAS_US * `RGR_CLK_MHZ)

`endif

//--- verilog/rgr_reset_gen.v
// Purpose: central reset generation, restart cause recording, hf clock default and failover
// Assumes: all source inputs are asynchronous levels, active high except the pin
// Notes:   all outputs registered; reset outputs released on clk
`timescale 1ns/1ps
`include "rgr_defs.vh"

// How it works
// - tap reset follows its pin only in jtag mode with debug port enabled.
// - deep-sleep reset held from entry request until low-voltage detector reports good.
// - emulated deep sleep keeps core and memory powered, resets only cpu core and core peripherals.
// - last restart cause recorded: supplies, pin, watchdog, software, wake, option failure.
// - cpu lockup flags a cause and halt, applies no reset.
// - power-on-domain reset covers cpu, debug components and interrupt controller.
// - cpu-core reset spares debug; debug access port reset separate.
// - always-on and core peripheral resets produced separately.
// - always-on por or cold low-voltage por asserts all five outputs.
// - low-voltage por from deep-sleep wake spares the always-on peripheral reset.
// - pin asserts all but dap; watchdog and software assert cpu and peripherals.
// - option failure, deep sleeps and debug reset use their own fixed masks.
// - internal rc oscillator selected as system clock whenever core powers up.
// - crystal failure forces rc clock and, if the crystal was the selected clock, raises a non-maskable interrupt.
// - crystal deemed usable only after 1 ms max bias or 2 ms optimal bias.
// - core and memory supply detectors merged into one low-voltage source.
module rgr_reset_gen #(
    parameter XTAL_MAXBIAS_CYC = `RGR_XTAL_MAXBIAS_CYC,
    parameter XTAL_OPTBIAS_CYC = `RGR_XTAL_OPTBIAS_CYC
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       always_on_supply_por,
    input  wire       core_supply_por,
    input  wire       mem_supply_por,
    input  wire       external_reset_pin_n,
    input  wire       watchdog_expired,
    input  wire       software_reset_request,
    input  wire       option_check_failure,
    input  wire       debug_reset_request,
    input  wire       deep_sleep_request,
    input  wire       emulated_sleep_mode,
    input  wire       cpu_lockup,
    input  wire       tap_reset_pin,
    input  wire       serial_wire_mode,
    input  wire       debug_port_enable,
    input  wire       xtal_select,
    input  wire       xtal_bias_max,
    input  wire       xtal_fail,
    output reg        power_on_domain_reset,
    output reg        cpu_core_reset,
    output reg        debug_access_port_reset,
    output reg        always_on_periph_reset,
    output reg        core_periph_reset,
    output reg        tap_reset,
    output reg        deep_sleep_reset,
    output reg  [3:0] reset_cause,
    output reg        lockup_halt,
    output reg        sys_clk_select,
    output reg        xtal_ready,
    output reg        xtal_fail_nmi
);

    localparam CW = 28;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    localparam NS = 17;
    wire [NS-1:0] raw_in = {xtal_fail, xtal_bias_max, xtal_select, debug_port_enable, serial_wire_mode,
                            tap_reset_pin, cpu_lockup, emulated_sleep_mode, deep_sleep_request,
                            debug_reset_request, option_check_failure, software_reset_request,
                            watchdog_expired, external_reset_pin_n, mem_supply_por, core_supply_por,
                            always_on_supply_por};
    reg  [NS-1:0] sync_a;
    reg  [NS-1:0] sync_b;

    // two flops per input; sync_a is read only by sync_b
    always @(posedge clk) begin
        sync_a <= raw_in;
        sync_b <= sync_a;
    end

    wire s_aon   = sync_b[0];
    wire s_lv    = sync_b[1] | sync_b[2];
    wire s_pin   = ~sync_b[3];    // pin is active low; inverted after the synchroniser
    wire s_wdog  = sync_b[4];
    wire s_swreq = sync_b[5];
    wire s_opt   = sync_b[6];
    wire s_dbg   = sync_b[7];
    wire s_dsreq = sync_b[8];
    wire s_emu   = sync_b[9];
    wire s_lock  = sync_b[10];
    wire s_tap   = sync_b[11];
    wire s_swd   = sync_b[12];
    wire s_dpen  = sync_b[13];
    wire s_xsel  = sync_b[14];
    wire s_xmax  = sync_b[15];
    wire s_xfail = sync_b[16];

    // ----------------------------------------------------------------
    // deep sleep tracking
    // ----------------------------------------------------------------
    reg  in_sleep;     // normal deep sleep in progress, power removed
    reg  emu_sleep;    // emulated deep sleep in progress
    reg  woke_sleep;   // last power-up of core came from deep sleep

    // held from request until lv detector reports good after wake
    // emulated sleep never removes power, so no lv wait
    always @(posedge clk) begin
        if (reset) begin
            in_sleep   <= 1'b0;
            emu_sleep  <= 1'b0;
            woke_sleep <= 1'b0;
        end else begin
            if (s_aon) begin
                in_sleep   <= 1'b0;
                emu_sleep  <= 1'b0;
                woke_sleep <= 1'b0;
            end else begin
                if (s_dsreq && !s_emu)
                    in_sleep <= 1'b1;
                else if (in_sleep && !s_dsreq && !s_lv)
                    in_sleep <= 1'b0;
                emu_sleep <= s_dsreq & s_emu;
                if (s_dsreq && !s_emu)
                    woke_sleep <= 1'b1;
                else if (!in_sleep && !s_lv)
                    woke_sleep <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // source to output map
    // ----------------------------------------------------------------
    reg [4:0] next_mask;

    // or of every active source mask
    always @* begin
        next_mask = 5'h00;
        if (s_aon)
            next_mask = next_mask | `RGR_MAP_AON_POR;
        if (s_lv && woke_sleep)
            next_mask = next_mask | `RGR_MAP_LV_WAKE;
        if (s_lv && !woke_sleep)
            next_mask = next_mask | `RGR_MAP_LV_COLD;
        if (s_pin)
            next_mask = next_mask | `RGR_MAP_PIN;
        if (s_wdog)
            next_mask = next_mask | `RGR_MAP_WDOG;
        if (s_swreq)
            next_mask = next_mask | `RGR_MAP_SWREQ;
        if (s_opt)
            next_mask = next_mask | `RGR_MAP_OPTFAIL;
        if (in_sleep)
            next_mask = next_mask | `RGR_MAP_DSLEEP;
        if (emu_sleep)
            next_mask = next_mask | `RGR_MAP_EMU_SLEEP;
        // request comes from debug port register bit
        if (s_dbg)
            next_mask = next_mask | `RGR_MAP_DBG;
    end

    // power-on domain cpu core and dap peripheral pair
    // the five reset outputs asserted and deep-sleep reset cleared during block reset so the system never runs half-reset
    always @(posedge clk) begin
        if (reset) begin
            power_on_domain_reset   <= 1'b1;
            cpu_core_reset          <= 1'b1;
            debug_access_port_reset <= 1'b1;
            always_on_periph_reset  <= 1'b1;
            core_periph_reset       <= 1'b1;
            deep_sleep_reset        <= 1'b0;
        end else begin
            power_on_domain_reset   <= next_mask[`RGR_OUT_POD];
            cpu_core_reset          <= next_mask[`RGR_OUT_CPU];
            debug_access_port_reset <= next_mask[`RGR_OUT_DAP];
            always_on_periph_reset  <= next_mask[`RGR_OUT_AON];
            core_periph_reset       <= next_mask[`RGR_OUT_CPER];
            deep_sleep_reset        <= in_sleep;
        end
    end

    // tap reset independent, masked in serial wire or disabled port
    always @(posedge clk) begin
        if (reset)
            tap_reset <= 1'b0;
        else
            tap_reset <= s_tap & s_dpen & ~s_swd;
    end

    // ----------------------------------------------------------------
    // cause recording
    // ----------------------------------------------------------------
    reg cpu_held;    // cpu reset was asserted last cycle

    // cause latched on rising cpu reset, priority by severity
    // not cleared by block reset, only overwritten by a new restart or a cpu lockup
    // lockup recorded and halts with no reset applied
    always @(posedge clk) begin
        cpu_held <= next_mask[`RGR_OUT_CPU];
        if (next_mask[`RGR_OUT_CPU] && !cpu_held) begin
            if (s_aon)
                reset_cause <= `RGR_CAUSE_AON_POR;
            else if (s_lv && !woke_sleep)
                reset_cause <= `RGR_CAUSE_LV_POR;
            else if (s_pin)
                reset_cause <= `RGR_CAUSE_PIN;
            else if (s_wdog)
                reset_cause <= `RGR_CAUSE_WDOG;
            else if (s_swreq)
                reset_cause <= `RGR_CAUSE_SWREQ;
            else if (s_opt)
                reset_cause <= `RGR_CAUSE_OPTFAIL;
            else if (in_sleep || emu_sleep || s_lv)
                reset_cause <= `RGR_CAUSE_WAKE;
        end else if (s_lock && !lockup_halt && !next_mask[`RGR_OUT_CPU]) // stale lockup during cpu reset ignored
            reset_cause <= `RGR_CAUSE_LOCKUP;
    end

    // lockup halt cleared only by a cpu reset, e.g. from the watchdog, or by block reset
    always @(posedge clk) begin
        if (reset)
            lockup_halt <= 1'b0;
        else if (next_mask[`RGR_OUT_CPU])
            lockup_halt <= 1'b0;
        else if (s_lock)
            lockup_halt <= 1'b1;
    end

    // ----------------------------------------------------------------
    // hf clock source, crystal start-up and failover
    // ----------------------------------------------------------------
    reg  [CW-1:0] xtal_cnt;
    wire [CW-1:0] xtal_limit = s_xmax ? XTAL_MAXBIAS_CYC[CW-1:0] : XTAL_OPTBIAS_CYC[CW-1:0];

    // start-up wait before crystal counted usable
    always @(posedge clk) begin
        if (reset || power_on_domain_reset || !s_xsel || s_xfail) begin
            xtal_cnt   <= {CW{1'b0}};
            xtal_ready <= 1'b0;
        end else if (xtal_cnt >= xtal_limit) begin
            xtal_ready <= 1'b1;
        end else begin
            xtal_cnt <= xtal_cnt + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // rc on core power-up failover and nmi pulse
    always @(posedge clk) begin
        if (reset || power_on_domain_reset) begin
            sys_clk_select <= `RGR_CLK_RC;
            xtal_fail_nmi  <= 1'b0;
        end else begin
            xtal_fail_nmi <= s_xfail & (sys_clk_select == `RGR_CLK_XTAL);
            if (s_xfail)
                sys_clk_select <= `RGR_CLK_RC;
            else if (xtal_ready && s_xsel)
                sys_clk_select <= `RGR_CLK_XTAL;
            else if (!s_xsel)
                sys_clk_select <= `RGR_CLK_RC;
        end
    end

endmodule // rgr_reset_gen

//--- verif/rgr_partner.sv
// Purpose: far-side model of supplies, pin, watchdog, cpu core and debug host
// Assumes: bench picks the active sources as one bit vector
// Notes:   lines change only just after a rising edge
`timescale 1ns/1ps
module rgr_partner (
    input  wire        clk,
    input  wire [10:0] sel,
    output reg  [10:0] src
);
    // all eleven source lines, three supplies through lockup, as levels
    always @(posedge clk) begin
        src <= sel;
    end
endmodule // rgr_partner

//--- verif/rgr_reset_gen_properties.sv
// Purpose: port-level properties of the reset generator
// Assumes: sources held for several cycles at a time
// Notes:   source to output takes three edges, five used for margin
`timescale 1ns/1ps
`include "rgr_defs.vh"
module rgr_reset_gen_properties (
    input wire       clk,
    input wire       reset,
    input wire       always_on_supply_por,
    input wire       core_supply_por,
    input wire       mem_supply_por,
    input wire       external_reset_pin_n,
    input wire       watchdog_expired,
    input wire       software_reset_request,
    input wire       option_check_failure,
    input wire       debug_reset_request,
    input wire       deep_sleep_request,
    input wire       cpu_lockup,
    input wire       tap_reset_pin,
    input wire       serial_wire_mode,
    input wire       debug_port_enable,
    input wire       xtal_fail,
    input wire       power_on_domain_reset,
    input wire       cpu_core_reset,
    input wire       debug_access_port_reset,
    input wire       always_on_periph_reset,
    input wire       core_periph_reset,
    input wire       tap_reset,
    input wire [3:0] reset_cause,
    input wire       lockup_halt,
    input wire       sys_clk_select,
    input wire       xtal_ready,
    input wire       xtal_fail_nmi
);
    reg  [2:0] warm_cnt;
    wire       warm = warm_cnt == 3'h7;
    wire [4:0] outs = {core_periph_reset, always_on_periph_reset, debug_access_port_reset, cpu_core_reset,
                       power_on_domain_reset};
    wire       quiet = !always_on_supply_por && !core_supply_por && !mem_supply_por && external_reset_pin_n &&
                       !watchdog_expired && !software_reset_request && !option_check_failure && !deep_sleep_request;
    // cycles since reset release, so $past never reaches back into reset
    always @(posedge clk) begin
        if (reset)
            warm_cnt <= 3'h0;
        else if (!warm)
            warm_cnt <= warm_cnt + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_aon_all: assert property ((warm && always_on_supply_por)[*5] |-> outs == 5'h1f)
        else $error("always-on por missed an output");
    a_pin_map: assert property ((warm && !external_reset_pin_n)[*5] |-> (outs & 5'h1b) == 5'h1b)
        else $error("pin reset missed an output");
    a_wdog_map: assert property ((warm && watchdog_expired)[*5] |-> (outs & 5'h1a) == 5'h1a)
        else $error("watchdog reset missed an output");
    a_dbg_only: assert property ((warm && quiet && debug_reset_request)[*5] |-> outs == 5'h02)
        else $error("debug reset mask wrong");
    a_all_release: assert property ((warm && quiet && !debug_reset_request)[*5] |-> outs == 5'h00)
        else $error("reset output held with no source");
    a_tap_follow: assert property ((warm && tap_reset_pin && !serial_wire_mode && debug_port_enable)[*5]
        |-> tap_reset)
        else $error("tap reset not applied");
    a_tap_refused: assert property ((warm && (serial_wire_mode || !debug_port_enable))[*5] |-> !tap_reset)
        else $error("tap reset applied while refused");
    a_lockup_nores: assert property ((warm && quiet && !debug_reset_request && cpu_lockup)[*5]
        |-> lockup_halt && !cpu_core_reset && reset_cause == `RGR_CAUSE_LOCKUP)
        else $error("lockup handling wrong");
    a_cause_hold: assert property (warm && $changed(reset_cause) |-> $rose(cpu_core_reset) || $rose(lockup_halt))
        else $error("cause changed without restart");
    a_failover: assert property ((warm && xtal_fail)[*5] |-> sys_clk_select == `RGR_CLK_RC)
        else $error("no failover to rc clock");
    a_xtal_gate: assert property ($rose(sys_clk_select) |-> $past(xtal_ready))
        else $error("crystal chosen before ready");
    c_lockup: cover property (lockup_halt);
    c_nmi: cover property (xtal_fail_nmi);
    c_xtal: cover property (sys_clk_select);
endmodule // rgr_reset_gen_properties
bind rgr_reset_gen rgr_reset_gen_properties chk_u (.clk, .reset, .always_on_supply_por, .core_supply_por,
    .mem_supply_por, .external_reset_pin_n, .watchdog_expired, .software_reset_request, .option_check_failure,
    .debug_reset_request, .deep_sleep_request, .cpu_lockup, .tap_reset_pin, .serial_wire_mode, .debug_port_enable,
    .xtal_fail, .power_on_domain_reset, .cpu_core_reset, .debug_access_port_reset, .always_on_periph_reset,
    .core_periph_reset, .tap_reset, .reset_cause, .lockup_halt, .sys_clk_select, .xtal_ready, .xtal_fail_nmi);

//--- verif/testbench.sv
// Purpose: self-checking bench for the reset generator
// Assumes: crystal counts shortened to 10 and 20 cycles
// Notes:   a bit-vector model predicts every output mask
`timescale 1ns/1ps
`include "rgr_defs.vh"
module testbench;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [10:0] sel = 11'h000;
    reg  [5:0]  jx = 6'h00;
    reg  [3:0]  cause_exp = 4'h0;
    reg         cause_ok = 1'b0;
    wire [10:0] src;
    wire [4:0]  rst;
    wire [3:0]  reset_cause;
    wire        tap_reset, deep_sleep_reset, lockup_halt, sys_clk_select, xtal_ready, xtal_fail_nmi;
    integer     error_cnt = 0;
    integer     tests_run = 0;
    integer     i, k;
    always #5 clk = ~clk;
    rgr_partner far_u (.clk(clk), .sel(sel), .src(src));
    rgr_reset_gen #(.XTAL_MAXBIAS_CYC(10), .XTAL_OPTBIAS_CYC(20)) dut_u (.clk(clk), .reset(reset),
        .always_on_supply_por(src[0]), .core_supply_por(src[1]), .mem_supply_por(src[2]),
        .external_reset_pin_n(!src[3]), .watchdog_expired(src[4]), .software_reset_request(src[5]),
        .option_check_failure(src[6]), .debug_reset_request(src[7]), .deep_sleep_request(src[8]),
        .emulated_sleep_mode(src[9]), .cpu_lockup(src[10]), .tap_reset_pin(jx[0]), .serial_wire_mode(jx[1]),
        .debug_port_enable(jx[2]), .xtal_select(jx[3]), .xtal_bias_max(jx[4]), .xtal_fail(jx[5]),
        .power_on_domain_reset(rst[0]), .cpu_core_reset(rst[1]), .debug_access_port_reset(rst[2]),
        .always_on_periph_reset(rst[3]), .core_periph_reset(rst[4]), .tap_reset(tap_reset),
        .deep_sleep_reset(deep_sleep_reset), .reset_cause(reset_cause), .lockup_halt(lockup_halt),
        .sys_clk_select(sys_clk_select), .xtal_ready(xtal_ready), .xtal_fail_nmi(xtal_fail_nmi));
    // model: sources OR their masks; w marks a supply loss while waking
    function [4:0] mask_of(input [10:0] s, input w);
        begin
            mask_of = (s[1] | s[2]) ? (w ? `RGR_MAP_LV_WAKE : `RGR_MAP_LV_COLD) : 5'h00;
            mask_of = mask_of | (s[0] ? `RGR_MAP_AON_POR : 5'h00) | (s[3] ? `RGR_MAP_PIN : 5'h00);
            mask_of = mask_of | (s[4] ? `RGR_MAP_WDOG : 5'h00) | (s[5] ? `RGR_MAP_SWREQ : 5'h00);
            mask_of = mask_of | (s[6] ? `RGR_MAP_OPTFAIL : 5'h00) | (s[7] ? `RGR_MAP_DBG : 5'h00);
            mask_of = mask_of | (s[8] ? (s[9] ? `RGR_MAP_EMU_SLEEP : `RGR_MAP_DSLEEP) : 5'h00);
        end
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // cause only predictable for listed sources; debug and sleep leave it unknown
    task apply(input [10:0] s, input w);
        begin
            @(posedge clk) sel <= s;
            repeat (8) @(posedge clk);
            #1;
            check(rst, mask_of(s, w));
            check(deep_sleep_reset, (s[8] && !s[9]) || w);
            if (|s[6:0] && !w) begin
                cause_exp = s[0] ? 4'h1 : (s[1] | s[2]) ? 4'h2 : s[3] ? 4'h3 : s[4] ? 4'h4 : s[5] ? 4'h5 : 4'h7;
                cause_ok = 1'b1;
                check(reset_cause, cause_exp);
            end else if (s[10]) begin
                cause_exp = `RGR_CAUSE_LOCKUP;
                cause_ok = 1'b1;
                check(reset_cause, cause_exp);
            end else if (s[7] | s[8] | w)
                cause_ok = 1'b0;
            else if (cause_ok)
                check(reset_cause, cause_exp);
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        k = $urandom(84);
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            apply((11'h001 << i) | (i == 9 ? 11'h100 : 11'h000), 1'b0);
            apply(11'h000, 1'b0);
        end
        $display("test done: single sources");
        for (i = 0; i < 8; i = i + 1) begin
            apply((11'h001 << ($urandom % 7)) | (11'h001 << ($urandom % 7)), 1'b0);
            apply(11'h000, 1'b0);
        end
        $display("test done: overlapping sources");
        apply(11'h100, 1'b0);
        apply(11'h102, 1'b1);
        apply(11'h002, 1'b1);
        apply(11'h000, 1'b0);
        check(reset_cause, `RGR_CAUSE_WAKE);
        $display("test done: deep sleep wake");
        apply(11'h001, 1'b0);
        apply(11'h400, 1'b0);
        check({lockup_halt, reset_cause}, {1'b1, `RGR_CAUSE_LOCKUP});
        cause_exp = `RGR_CAUSE_LOCKUP;
        apply(11'h410, 1'b0);
        check(lockup_halt, 1'b0);
        apply(11'h000, 1'b0);
        $display("test done: lockup");
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk) jx <= i[5:0];
            repeat (6) @(posedge clk);
            #1 check(tap_reset, i[0] & !i[1] & i[2]);
        end
        $display("test done: tap reset");
        @(posedge clk) jx <= 6'h08;
        repeat (15) @(posedge clk);
        #1 check(sys_clk_select, `RGR_CLK_RC);
        repeat (25) @(posedge clk);
        #1 check({xtal_ready, sys_clk_select}, {1'b1, `RGR_CLK_XTAL});
        @(posedge clk) jx <= 6'h28;
        k = 0;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            #1 k = k + xtal_fail_nmi;
        end
        check(k[15:0], 16'h0001);
        check(sys_clk_select, `RGR_CLK_RC);
        // max bias: ready after the shorter wait, well before the optimal-bias count
        @(posedge clk) jx <= 6'h18;
        repeat (9) @(posedge clk);
        #1 check(xtal_ready, 1'b0);
        repeat (6) @(posedge clk);
        #1 check({xtal_ready, sys_clk_select}, {1'b1, `RGR_CLK_XTAL});
        $display("test done: crystal failover");
        @(posedge clk) jx <= 6'h00;
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1 check({sys_clk_select, reset_cause}, {`RGR_CLK_RC, cause_exp});
        $display("test done: mid-run reset");
        results;
    end
    // hang guard, well beyond the roughly 535 cycles the tests need
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        results;
    end
endmodule // testbench
